/* File: verilog/rtcu_top.sv */
// rotate-through-carry slice of the core alu
module rtcu_top
   import rtcu_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire logic [INSTR_W-1:0] instr,
   input wire logic [DATA_W-1:0] file_rdata,
   input wire logic status_carry,
   output logic [1:0] phase,
   output logic busy,
   output logic [ADDR_W-1:0] file_addr,
   output logic file_we,
   output logic w_we,
   output logic [DATA_W-1:0] result_data,
   output logic carry_we,
   output logic carry_data
);
   logic rst_meta_q;
   logic rst_n_q;
   rtcu_phase_type phase_q;
   logic busy_q;
   logic left_q;
   logic dest_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] src_q;
   logic cin_q;
   logic [DATA_W-1:0] rot_data;
   logic rot_carry;
   logic [DATA_W-1:0] result_q;
   logic carry_q;
   logic file_we_q;
   logic w_we_q;
   logic [5:0] opc;
   logic is_rot;

   // reset release through two flops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   assign opc = instr[OPC_MSB:OPC_LSB];
   assign is_rot = (opc == OPC_ROT_LEFT) || (opc == OPC_ROT_RIGHT);

   // four-phase instruction cycle
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         phase_q <= PH_Q1;
      end else if (clk_en) begin
         phase_q <= rtcu_phase_type'(phase_q + PHASE_STEP);
      end
   end

   // instruction capture at the first phase
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         busy_q <= 1'b0;
         left_q <= 1'b0;
         dest_q <= DEST_F;
         addr_q <= '0;
      end else if (clk_en && phase_q == PH_Q1) begin
         busy_q <= instr_valid && is_rot;
         left_q <= (opc == OPC_ROT_LEFT);
         dest_q <= instr[DEST_BIT];
         addr_q <= instr[ADDR_MSB:0];
      end
   end

   // operand read during the second phase
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         src_q <= '0;
         cin_q <= 1'b0;
      end else if (clk_en && phase_q == PH_Q2 && busy_q) begin
         src_q <= file_rdata;
         cin_q <= status_carry;
      end
   end

   rtcu_rotator u_rot (
      .dir_left(left_q),
      .din(src_q),
      .cin(cin_q),
      .dout(rot_data),
      .cout(rot_carry)
   );

   // result and write strobes, one phase wide in the last phase
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         result_q <= '0;
         carry_q <= 1'b0;
         file_we_q <= 1'b0;
         w_we_q <= 1'b0;
      end else if (clk_en) begin
         if (phase_q == PH_Q3 && busy_q) begin
            result_q <= rot_data;
            carry_q <= rot_carry;
            file_we_q <= (dest_q == DEST_F);
            w_we_q <= (dest_q == DEST_W);
         end else begin
            file_we_q <= 1'b0;
            w_we_q <= 1'b0;
         end
      end
   end

   assign phase = phase_q;
   assign busy = busy_q;
   assign file_addr = addr_q;
   assign file_we = file_we_q;
   assign w_we = w_we_q;
   assign result_data = result_q;
   assign carry_we = file_we_q || w_we_q;
   assign carry_data = carry_q;

   rot_left_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      carry_we && left_q |->
         result_data == {src_q[6:0], cin_q} && carry_data == src_q[7])
      else $error("rotate left result wrong");

   rot_right_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      carry_we && !left_q |->
         result_data == {cin_q, src_q[7:1]} && carry_data == src_q[0])
      else $error("rotate right result wrong");

   left_dec_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en && phase_q == PH_Q1 && instr_valid && is_rot |=>
         left_q == $past(instr[OPC_LSB]))
      else $error("rotate direction not decoded");

   carry_src_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en && phase_q == PH_Q2 && busy_q |=> cin_q == $past(status_carry))
      else $error("carry not taken from status");

   src_hold_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      !(clk_en && phase_q == PH_Q2 && busy_q) |=>
         $stable(src_q) && $stable(cin_q))
      else $error("operand changed outside its read phase");

   dest_acc_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      w_we |-> !file_we && dest_q == DEST_W)
      else $error("accumulator write with wrong destination");

   dest_file_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      file_we |->
         !w_we && dest_q == DEST_F && file_addr == $past(file_addr, 2))
      else $error("file write with wrong destination");

   addr_take_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en && phase_q == PH_Q1 && instr_valid && is_rot |=>
         busy_q && file_addr == $past(instr[4:0]) && dest_q == $past(instr[5]))
      else $error("operand not captured");

   addr_hold_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      !(clk_en && phase_q == PH_Q1) |=> $stable(file_addr) && $stable(busy))
      else $error("address changed outside capture phase");

   one_strobe_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      carry_we |-> ((phase_q == PH_Q4) and (clk_en |=> !carry_we)))
      else $error("write strobe outside last phase or too long");

   one_cycle_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en && phase_q == PH_Q1 && instr_valid && is_rot ##1 clk_en [*2]
         |=> carry_we)
      else $error("rotate not finished in one instruction cycle");

   result_hold_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      !(clk_en && phase_q == PH_Q3 && busy_q) |=>
         $stable(result_data) && $stable(carry_data))
      else $error("result changed before the next rotate");

   en_freeze_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      !clk_en |=> $stable(phase_q) && $stable(busy_q) && $stable(file_addr) &&
         $stable(src_q) && $stable(carry_we))
      else $error("state moved while clock enable low");

   non_rot_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en && phase_q == PH_Q1 && !(instr_valid && is_rot) |=> !busy_q)
      else $error("non-rotate instruction accepted");

   idle_quiet_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      !busy_q |-> !carry_we)
      else $error("write strobe without a rotate");

   phase_step_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en && phase_q == PH_Q1 ##1 clk_en [*3] |=> phase_q == PH_Q1)
      else $error("instruction cycle not four phases");

   phase_order_a: assert property (@(posedge mclk)
      disable iff (!rst_n_q)
      clk_en |=> phase_q == rtcu_phase_type'($past(phase_q) + PHASE_STEP))
      else $error("phase did not advance by one");

   reset_idle_a: assert property (@(posedge mclk)
      !rst_n_q |-> phase_q == PH_Q1 && !busy && !carry_we)
      else $error("outputs not idle in reset");
endmodule // rtcu_top

/* File: inc/rtcu_pkg.sv */
// constants and types for the rotate-through-carry unit
package rtcu_pkg;
   localparam int OPC_MSB = 11;
   localparam int OPC_LSB = 6;
   localparam int DEST_BIT = 5;
   localparam int ADDR_MSB = 4;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int INSTR_W = 12;
   localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
   localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
   localparam logic DEST_W = 1'b0;
   localparam logic DEST_F = 1'b1;
   localparam int STATUS_CARRY_BIT = 0;
   localparam int OSC_PERIOD_NS = 4;
   localparam int INSTR_CYCLE_NS = 16;
   localparam int PHASES_PER_INSTR = INSTR_CYCLE_NS / OSC_PERIOD_NS;
   localparam logic [1:0] PHASE_STEP = 2'h1;

   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } rtcu_phase_type;
endpackage

/* File: verilog/rtcu_rotator.sv */
// one-bit rotate of a byte through a carry bit
module rtcu_rotator
   import rtcu_pkg::*;
(
   input wire logic dir_left,
   input wire logic [DATA_W-1:0] din,
   input wire logic cin,
   output logic [DATA_W-1:0] dout,
   output logic cout
);
   always_comb begin
      if (dir_left) begin
         dout = {din[DATA_W-2:0], cin};
         cout = din[DATA_W-1];
      end else begin
         dout = {cin, din[DATA_W-1:1]};
         cout = din[0];
      end
   end
endmodule // rtcu_rotator

/* File: dv/rtcu_core_model.sv */
// far-side model: file registers, accumulator and carry flag
module rtcu_core_model (
   input wire logic mclk,
   input wire logic [4:0] file_addr,
   input wire logic file_we,
   input wire logic w_we,
   input wire logic carry_we,
   input wire logic carry_data,
   input wire logic [7:0] result_data,
   output logic [7:0] file_rdata,
   output logic status_carry
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [32];
   logic [7:0] w;
   logic c;
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 8'he6 ^ 8'(i * 7);
      w = 8'h00;
      c = 1'b0;
   end
   assign file_rdata = mem[file_addr];
   assign status_carry = c;
   always @(posedge mclk) begin
      if (file_we) mem[file_addr] <= result_data;
      if (w_we) w <= result_data;
      if (carry_we) c <= carry_data;
   end
endmodule // rtcu_core_model

/* File: dv/rotate_through_carry_unit_tb.sv */
// self-checking bench for the rotate-through-carry unit
module rotate_through_carry_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rtcu_pkg::*;
   logic mclk, resetn, clk_en, instr_valid, status_carry;
   logic [11:0] instr;
   logic [7:0] file_rdata, result_data;
   logic [1:0] phase;
   logic busy, file_we, w_we, carry_we, carry_data;
   logic [4:0] file_addr;
   int n_errors = 0;
   int num_checks = 0;
   rtcu_top dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
      .status_carry(status_carry), .phase(phase), .busy(busy),
      .file_addr(file_addr), .file_we(file_we), .w_we(w_we),
      .result_data(result_data), .carry_we(carry_we),
      .carry_data(carry_data));
   rtcu_core_model m (.mclk(mclk), .file_addr(file_addr),
      .file_we(file_we), .w_we(w_we), .carry_we(carry_we),
      .carry_data(carry_data), .result_data(result_data),
      .file_rdata(file_rdata), .status_carry(status_carry));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rot(input logic [5:0] op, input logic d,
                      input logic [4:0] f, input int stall);
      logic [7:0] v, e, w0;
      logic ec;
      while (phase !== 2'h0) @(negedge mclk);
      v = m.mem[f];
      w0 = m.w;
      if (op == OPC_ROT_LEFT) {ec, e} = {v, m.c};
      else {ec, e} = {v[0], m.c, v[7:1]};
      instr = {op, d, f};
      instr_valid = 1'b1;
      @(negedge mclk);
      instr_valid = 1'b0;
      chk({busy, 1'b0, phase, file_addr}, {1'b1, 1'b0, 2'h1, f});
      if (stall > 0) begin
         clk_en = 1'b0;
         repeat (stall) @(negedge mclk);
         chk({busy, carry_we, phase, file_addr}, {1'b1, 1'b0, 2'h1, f});
         clk_en = 1'b1;
      end
      repeat (2) @(negedge mclk);
      chk({file_we, w_we, carry_we, 4'h0, phase}, {d, !d, 1'b1, 4'h0, 2'h3});
      chk({carry_data, result_data}, {ec, e});
      @(negedge mclk);
      chk({file_we, w_we, carry_we, 4'h0, phase}, 9'h0);
      chk({1'b0, m.mem[f]}, {1'b0, d ? e : v});
      chk({m.c, m.w}, {ec, d ? w0 : e});
   endtask
   task automatic t_rotates();
      for (int k = 0; k < 8; k++)
         rot(k[0] ? OPC_ROT_LEFT : OPC_ROT_RIGHT, k[1], {5{k[2]}}, 0);
      rot(OPC_ROT_LEFT, 1'b1, 5'h0a, 2);
      $display("rotates done");
   endtask
   task automatic t_refused();
      for (int k = 0; k < 2; k++) begin
         while (phase !== 2'h0) @(negedge mclk);
         instr = {(k[0] ? OPC_ROT_LEFT : 6'h0e), 6'h25};
         if (!k[0]) instr_valid = 1'b1;
         repeat (4) begin
            @(negedge mclk);
            instr_valid = 1'b0;
            chk({5'h0, busy, file_we, w_we, carry_we}, 9'h0);
         end
      end
      $display("refused done");
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr = 12'h000;
      repeat (12) @(negedge mclk);
      resetn = 1'b1;
      repeat (2) @(negedge mclk);
      chk({busy, file_we, w_we, carry_we, 3'h0, phase}, 9'h0);
      t_rotates();
      t_refused();
      test_done();
   end
   initial begin
      repeat (2000) @(posedge mclk);
      n_errors++;
      test_done();
   end
endmodule // rotate_through_carry_unit_tb
